// [logic/fault_cfg_decode.sv]
`include "fault_cfg_map.svh"
// ==========================================================
// decodes code fields into physical quantities
module fault_cfg_decode
	import fault_cfg_pkg::*;
(
	// codes
	input  wire logic [7:0]  thr_code,
	input  wire logic [1:0]  ratio_code,
	input  wire logic [4:0]  sup_code,
	input  wire logic [3:0]  blank_code,
	// decoded values
	output logic      [15:0] thr_mv,
	output logic      [9:0]  ratio,
	output logic      [15:0] sup_mv,
	output logic      [15:0] blank_us
);
	// scaling and lookup
	always_comb begin
		thr_mv = 16'(thr_code * `THR_STEP_MV) + `THR_BASE_MV;
		ratio  = 10'(10'd64 << ratio_code);
		sup_mv = 16'(sup_code * `SUP_STEP_MV) + `SUP_BASE_MV;
		case (blank_code)
			4'h0: blank_us = 16'd100;
			4'h1: blank_us = 16'd20;
			4'h2: blank_us = 16'd30;
			4'h3: blank_us = 16'd50;
			4'h4: blank_us = 16'd80;
			4'h5: blank_us = 16'd150;
			4'h6: blank_us = 16'd200;
			4'h7: blank_us = 16'd300;
			4'h8: blank_us = 16'd500;
			4'h9: blank_us = 16'd800;
			4'ha: blank_us = 16'd1000;
			4'hb: blank_us = 16'd1200;
			4'hc: blank_us = 16'd1500;
			4'hd: blank_us = 16'd2000;
			4'he: blank_us = 16'd3000;
			default: blank_us = 16'd4000;
		endcase
	end
endmodule

// [logic/fault_cfg_map.svh]
`ifndef FAULT_CFG_MAP_SVH
`define FAULT_CFG_MAP_SVH
// Summary of operation
// - reset reloads every field from nonvolatile copy
// - threshold B code at 0x79, 0.125V steps
// - bit 7 enables single-LED short check
// - ratio code 0..3 gives 64..512
// - low-supply threshold is code*1V plus 4V
// - retry current is (code*4+4)/64 full range
// - blanking code selects 20us..4ms table
// - mask bit one blocks fault report
// - device mask bits 7..2 map six faults
// - output mask bits 2,1,0 open/short/single-LED
// - unused mask bits read zero always
// - per-channel select picks threshold A or B
// - threshold A code at 0x78, same scale
// ==========================================================
// register offsets
`define OFS_THR_A       8'h78
`define OFS_THR_B       8'h79
`define OFS_REF_CFG     8'h7a
`define OFS_TIMING_CFG  8'h7b
`define OFS_DEV_MASK    8'h7c
`define OFS_OUT_MASK    8'h7d
`define OFS_SEL_BASE    8'h70
`define OFS_IRQ_STAT    8'h90
`define OFS_IRQ_MASK    8'h91
// ==========================================================
// field positions and writable bits
`define BIT_SLS_EN      7
`define DEV_MASK_WR     8'hfc
`define OUT_MASK_WR     8'h07
`define SEL_WR          8'h77
// ==========================================================
// voltage scaling in millivolts
`define THR_STEP_MV     16'd125
`define THR_BASE_MV     16'd2500
`define SUP_STEP_MV     16'd1000
`define SUP_BASE_MV     16'd4000
// ==========================================================
// timing and nonvolatile load
`define CLK_MHZ         125
`define NVM_LOAD_CYCLES 4'd10
`endif

// [logic/fault_cfg_nvm_image.sv]
`include "fault_cfg_map.svh"
// ==========================================================
// nonvolatile image: holds programmed values, registered read
module fault_cfg_nvm_image
	import fault_cfg_pkg::*;
#(
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// programming port
	input  wire logic       prog_we,
	input  wire logic [3:0] prog_addr,
	input  wire logic [7:0] prog_data,
	// read port
	input  wire logic [3:0] rd_addr,
	output logic      [7:0] rd_data
);
	logic [7:0] mem [DEPTH];  // programmed contents
	logic [7:0] rd_data_d;    // next read word

	// address select
	always_comb begin
		rd_data_d = mem[rd_addr];
	end

	// storage kept over reset, like real nonvolatile cells
	always_ff @(posedge clk_sys) begin
		if (prog_we) begin
			mem[prog_addr] <= prog_data;
		end
	end

	// registered read data
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= rd_data_d;
		end
	end
endmodule

// [logic/fault_cfg_pkg.sv]
package fault_cfg_pkg;
	// state of the nonvolatile reload sequence
	typedef enum logic [1:0] {LOAD_IDLE, LOAD_RUN, LOAD_DONE} load_state_t;
endpackage

// [logic/led_fault_check_config_bank.sv]
// The plain strobed port was left to the implementer.
`include "fault_cfg_map.svh"
// ==========================================================
// fault-check configuration bank with nonvolatile reload
module led_fault_check_config_bank
	import fault_cfg_pkg::*;
#(
	parameter int CHANNELS = 24
) (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	// register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	// nonvolatile programming port
	input  wire logic                prog_we,
	input  wire logic [3:0]          prog_addr,
	input  wire logic [7:0]          prog_data,
	// raw faults from detectors, same clock
	input  wire logic [5:0]          dev_fault_raw,
	input  wire logic [2:0]          out_fault_raw,
	// configuration outputs
	output logic                     single_led_short_check_enable,
	output logic      [9:0]          current_ratio,
	output logic      [3:0]          retry_current_code,
	output logic      [15:0]         low_supply_mv,
	output logic      [15:0]         blank_us,
	output logic      [15:0]         short_threshold_a_mv,
	output logic      [15:0]         short_threshold_b_mv,
	output logic      [CHANNELS-1:0] channel_uses_b,
	// reported faults and interrupt
	output logic      [5:0]          dev_fault_report,
	output logic      [2:0]          out_fault_report,
	output logic                     load_busy,
	output logic                     irq
);
	localparam int SEL_REGS = (CHANNELS + 5) / 6;   // selection registers
	localparam int NREG     = 6 + SEL_REGS;         // image words used

	// ==========================================================
	// register state
	logic [7:0] cfg_q [NREG];     // 0:A 1:B 2:ref 3:timing 4:dev 5:out 6+:select
	logic [7:0] cfg_d [NREG];
	logic [7:0] irq_stat_q, irq_stat_d;  // sticky events
	logic [7:0] irq_mask_q, irq_mask_d;  // one enables an event
	logic [7:0] reg_rdata_d;
	load_state_t st_q, st_d;             // reload sequencer
	logic [3:0] idx_q, idx_d;            // word being fetched
	logic [3:0] rd_addr;                 // image address
	logic [7:0] nvm_data;                // image word, one cycle late
	logic [5:0] dev_prev_q;              // edge detection of faults
	logic [2:0] out_prev_q;
	logic [7:0] events;                  // rising reported faults

	// write masks per index, read-only bits keep zero
	function automatic logic [7:0] wr_mask(input int i);
		if (i == 4) begin
			wr_mask = `DEV_MASK_WR;
		end else if (i == 5) begin
			wr_mask = `OUT_MASK_WR;
		end else if (i >= 6) begin
			wr_mask = `SEL_WR;
		end else begin
			wr_mask = 8'hff;
		end
	endfunction

	// maps a bus address to an index, or -1
	function automatic int reg_index(input logic [7:0] a);
		if (a >= `OFS_THR_A && a <= `OFS_OUT_MASK) begin
			reg_index = int'(a - `OFS_THR_A);
		end else if (a >= `OFS_SEL_BASE && a < 8'(`OFS_SEL_BASE + SEL_REGS)) begin
			reg_index = 6 + int'(a - `OFS_SEL_BASE);
		end else begin
			reg_index = -1;
		end
	endfunction

	// image fetched in order of index
	fault_cfg_nvm_image #(.DEPTH(16)) u_nvm (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.prog_we   (prog_we),
		.prog_addr (prog_addr),
		.prog_data (prog_data),
		.rd_addr   (rd_addr),
		.rd_data   (nvm_data)
	);
	assign rd_addr = idx_q;

	// ==========================================================
	// reload sequencer: walks the image after every reset
	always_comb begin
		st_d  = st_q;
		idx_d = idx_q;
		case (st_q)
			LOAD_IDLE: begin
				st_d  = LOAD_RUN;
				idx_d = 4'd0;
			end
			LOAD_RUN: begin
				idx_d = idx_q + 4'd1;
				if (idx_q == 4'(NREG)) begin
					st_d = LOAD_DONE;
				end
			end
			default: begin
				st_d = LOAD_DONE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q  <= LOAD_IDLE;
			idx_q <= 4'd0;
		end else begin
			st_q  <= st_d;
			idx_q <= idx_d;
		end
	end

	assign load_busy = (st_q != LOAD_DONE);

	// ==========================================================
	// configuration words: reload, then software writes
	always_comb begin
		for (int i = 0; i < NREG; i++) begin
			cfg_d[i] = cfg_q[i];
			if (st_q == LOAD_RUN && int'(idx_q) == i + 1) begin
				cfg_d[i] = nvm_data & wr_mask(i);
			end else if (!load_busy && reg_wr && reg_index(reg_addr) == i) begin
				cfg_d[i] = reg_wdata & wr_mask(i);
			end
		end
	end

	// per-word registers
	generate
		for (genvar g = 0; g < NREG; g++) begin : g_cfg
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					cfg_q[g] <= 8'h00;
				end else begin
					cfg_q[g] <= cfg_d[g];
				end
			end
		end
		// per-channel threshold selection, 3 per nibble
		for (genvar c = 0; c < CHANNELS; c++) begin : g_sel
			assign channel_uses_b[c] = cfg_q[6 + c / 6][(c % 6) / 3 * 4 + c % 3];
		end
	endgenerate

	// ==========================================================
	// field outputs
	assign single_led_short_check_enable = cfg_q[2][`BIT_SLS_EN];
	assign retry_current_code            = cfg_q[3][7:4];

	fault_cfg_decode u_dec_a (
		.thr_code   (cfg_q[0]),
		.ratio_code (cfg_q[2][6:5]),
		.sup_code   (cfg_q[2][4:0]),
		.blank_code (cfg_q[3][3:0]),
		.thr_mv     (short_threshold_a_mv),
		.ratio      (current_ratio),
		.sup_mv     (low_supply_mv),
		.blank_us   (blank_us)
	);
	fault_cfg_decode u_dec_b (
		.thr_code   (cfg_q[1]),
		.ratio_code (2'd0),
		.sup_code   (5'd0),
		.blank_code (4'd0),
		.thr_mv     (short_threshold_b_mv),
		.ratio      (),
		.sup_mv     (),
		.blank_us   ()
	);

	// ==========================================================
	// fault gating: a one blocks the report
	always_comb begin
		dev_fault_report = dev_fault_raw & ~cfg_q[4][7:2];
		out_fault_report = out_fault_raw & ~cfg_q[5][2:0];
		events = {2'b00, (dev_fault_report & ~dev_prev_q)} |
			{5'b00000, (out_fault_report & ~out_prev_q)};
	end

	// ==========================================================
	// interrupt status: set wins over write-one-clear
	always_comb begin
		irq_stat_d = irq_stat_q;
		irq_mask_d = irq_mask_q;
		if (reg_wr && reg_addr == `OFS_IRQ_STAT) begin
			irq_stat_d = irq_stat_q & ~reg_wdata;
		end
		irq_stat_d = irq_stat_d | events;
		if (reg_wr && reg_addr == `OFS_IRQ_MASK) begin
			irq_mask_d = reg_wdata;
		end
	end

	// interrupt and edge registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_q <= 8'h00;
			irq_mask_q <= 8'h00;
			dev_prev_q <= 6'h00;
			out_prev_q <= 3'h0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			dev_prev_q <= dev_fault_report;
			out_prev_q <= out_fault_report;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// ==========================================================
	// read mux, data valid the cycle after the strobe
	always_comb begin
		reg_rdata_d = 8'h00;
		if (reg_rd) begin
			if (reg_addr == `OFS_IRQ_STAT) begin
				reg_rdata_d = irq_stat_q;
			end else if (reg_addr == `OFS_IRQ_MASK) begin
				reg_rdata_d = irq_mask_q;
			end else if (reg_index(reg_addr) >= 0) begin
				reg_rdata_d = cfg_q[reg_index(reg_addr)];
			end
		end
	end

	// read data register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rdata_d;
		end
	end

	// ==========================================================
	// checks
	// reserved output mask bits never hold a one
	a_out_mask_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg_q[5][7:3] == 5'd0)) else $error("output mask upper bits set");
	// reserved device mask bits never hold a one
	a_dev_mask_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg_q[4][1:0] == 2'd0)) else $error("device mask low bits set");
	// a set output mask bit 0 hides output fault 0
	a_mask_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg_q[5][0] |-> !out_fault_report[0])) else $error("masked fault reported");
	// the low-supply mask sits in the top device bit
	a_dev_mask_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg_q[4][7] |-> !dev_fault_report[5])) else $error("low-supply fault not masked");
	// a write after reload lands whole in threshold b
	a_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!load_busy && reg_wr && reg_addr == `OFS_THR_B) |=> (cfg_q[1] == $past(reg_wdata)))
		else $error("threshold write lost");
	// read-only bits of the output mask drop on write
	a_write_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!load_busy && reg_wr && reg_addr == `OFS_OUT_MASK) |=>
		(cfg_q[5] == ($past(reg_wdata) & 8'h07))) else $error("mask write wrong");
	// reload ends within a bounded time after reset
	a_load_bounded: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> ##[1:20] !load_busy) else $error("reload too long");
	// the first image word lands in threshold a
	a_reload_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_q == LOAD_RUN && idx_q == 4'd1) |=> (cfg_q[0] == $past(nvm_data)))
		else $error("reload word lost");
	// the reloaded enable bit reaches the check enable output
	a_sls_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_q == LOAD_RUN && idx_q == 4'd3) |=>
		(single_led_short_check_enable == $past(nvm_data[7]))) else $error("enable wrong");
	// top ratio code gives the largest ratio
	a_ratio_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg_q[2][6:5] == 2'd3) |-> (current_ratio == 10'd512)) else $error("ratio");
	// code zero of threshold b sits at the base voltage
	a_thr_base: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg_q[1] == 8'h00) |-> (short_threshold_b_mv == `THR_BASE_MV))
		else $error("threshold base wrong");
	// an unmasked event raises the interrupt next cycle
	a_irq_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(events[0] && irq_mask_q[0]) |=> irq) else $error("irq missing");
	// writing one clears a status bit with no event pending
	a_irq_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(reg_wr && reg_addr == `OFS_IRQ_STAT && reg_wdata[1] && !events[1]) |=>
		!irq_stat_q[1]) else $error("status not cleared");
	// read data is zero outside its one valid cycle
	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!reg_rd |=> (reg_rdata == 8'h00)) else $error("read data not idle");
	// ==========================================================
	// main scenarios reached
	c_load_done: cover property (@(posedge clk_sys) $fell(load_busy));
	c_irq: cover property (@(posedge clk_sys) $rose(irq));
	c_thr_b: cover property (@(posedge clk_sys) channel_uses_b[0]);
	c_w1c: cover property (@(posedge clk_sys) reg_wr && reg_addr == `OFS_IRQ_STAT && |irq_stat_q);
	c_busy_write: cover property (@(posedge clk_sys) load_busy && reg_wr);
endmodule

// [verification/tb_led_fault_check_config_bank.sv]
`include "fault_cfg_map.svh"
// ==========================================================
// self-checking bench for the fault-check configuration bank
module tb_led_fault_check_config_bank;
	timeunit 1ns;
	timeprecision 1ps;
	// clock and reset
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	// register port
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	// nonvolatile programming port
	logic        prog_we;
	logic [3:0]  prog_addr;
	logic [7:0]  prog_data;
	// faults
	logic [5:0]  dev_fault_raw;
	logic [2:0]  out_fault_raw;
	logic [5:0]  dev_fault_report;
	logic [2:0]  out_fault_report;
	// configuration outputs
	logic        single_led_short_check_enable;
	logic [9:0]  current_ratio;
	logic [3:0]  retry_current_code;
	logic [15:0] low_supply_mv;
	logic [15:0] blank_us;
	logic [15:0] short_threshold_a_mv;
	logic [15:0] short_threshold_b_mv;
	logic [23:0] channel_uses_b;
	logic        load_busy;
	logic        irq;
	// bookkeeping
	int          n_fail = 0;
	int          total_checks = 0;
	int          seed = 35;
	int          i;
	int          c;
	logic        rd_seen = 1'b0;
	logic [7:0]  exp_q[$];
	logic [7:0]  d;
	logic [7:0]  m2;
	logic [7:0]  img[10];
	logic [7:0]  sel[4];
	logic [23:0] ecb;
	// register offsets and the bits that read back
	logic [7:0]  adr[10] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h70, 8'h71, 8'h72, 8'h73};
	logic [7:0]  rmask[10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfc, 8'h07, 8'h77, 8'h77, 8'h77, 8'h77};
	int          bt[16] = '{100, 20, 30, 50, 80, 150, 200, 300, 500, 800,
		1000, 1200, 1500, 2000, 3000, 4000};

	// ==========================================================
	// clock and device
	always #4 clk_sys = ~clk_sys;

	led_fault_check_config_bank #(.CHANNELS(24)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
		.dev_fault_raw(dev_fault_raw), .out_fault_raw(out_fault_raw),
		.single_led_short_check_enable(single_led_short_check_enable),
		.current_ratio(current_ratio), .retry_current_code(retry_current_code),
		.low_supply_mv(low_supply_mv), .blank_us(blank_us),
		.short_threshold_a_mv(short_threshold_a_mv), .short_threshold_b_mv(short_threshold_b_mv),
		.channel_uses_b(channel_uses_b),
		.dev_fault_report(dev_fault_report), .out_fault_report(out_fault_report),
		.load_busy(load_busy), .irq(irq)
	);

	// ==========================================================
	// compare tasks and closing report
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: read data %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: output %0d, wanted %0d", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// bus master: one-cycle strobes driven just after the edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// a read notes what it expects; the monitor checks it
	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		exp_q.push_back(v);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask

	// read data stands in the cycle after the strobe: compare mid-cycle
	always @(posedge clk_sys) begin
		rd_seen <= reg_rd;
	end
	always @(negedge clk_sys) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) begin
				n_fail++;
				$display("unexpected at %0t: read data with no note", $time);
			end else begin
				chk_rd(reg_rdata, exp_q.pop_front());
			end
		end
	end

	// reset held ten cycles, then a bounded wait for the reload
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
	endtask

	task automatic wait_load;
		int k;
		for (k = 0; k < 100 && load_busy !== 1'b0; k++) @(posedge clk_sys);
		if (load_busy !== 1'b0) begin
			n_fail++;
			$display("unexpected at %0t: reload never finished", $time);
			test_done;
		end
	endtask

	// fresh random image into the nonvolatile store, one word a cycle
	task automatic prog_image;
		for (int k = 0; k < 10; k++) begin
			img[k] = 8'($random(seed));
			@(posedge clk_sys);
			prog_we <= 1'b1;
			prog_addr <= 4'(k);
			prog_data <= img[k];
		end
		@(posedge clk_sys);
		prog_we <= 1'b0;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{prog_we, prog_addr, prog_data, dev_fault_raw, out_fault_raw} = '0;
		// first image programmed while reset is held, its last word one cycle after release
		fork
			do_reset;
			prog_image;
		join
		wait_load;
		for (i = 0; i < 10; i++) rd(adr[i], img[i] & rmask[i]);
		// a new image, reloaded by a second reset in mid-run
		prog_image;
		do_reset;
		wr(`OFS_THR_B, ~img[1]);
		#1 chk_val(24'(load_busy), 24'h1);
		wait_load;
		for (i = 0; i < 10; i++) rd(adr[i], img[i] & rmask[i]);
		// random writes, read-only bits dropped
		for (i = 0; i < 10; i++) begin
			d = 8'($random(seed));
			wr(adr[i], d);
			rd(adr[i], d & rmask[i]);
		end
		rd(8'h55, 8'h00);
		// channel threshold selection
		for (i = 0; i < 4; i++) begin
			sel[i] = 8'($random(seed));
			wr(`OFS_SEL_BASE + 8'(i), sel[i]);
		end
		for (c = 0; c < 24; c++) ecb[c] = sel[c / 6][(c % 6 < 3) ? c % 6 : c % 6 + 1];
		#1 chk_val(channel_uses_b, ecb);
		// threshold scaling at both ends of the code
		for (i = 0; i < 3; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			wr(`OFS_THR_A, d);
			wr(`OFS_THR_B, ~d);
			#1 chk_val(24'(short_threshold_a_mv), 24'(int'(d) * 125 + 2500));
			chk_val(24'(short_threshold_b_mv), 24'(int'(8'(~d)) * 125 + 2500));
		end
		// every ratio code, enable toggled, random supply code
		for (i = 0; i < 4; i++) begin
			d = {i[0], i[1:0], 5'($random(seed))};
			wr(`OFS_REF_CFG, d);
			#1 chk_val(24'(single_led_short_check_enable), 24'(i[0]));
			chk_val(24'(current_ratio), 24'(64 << i));
			chk_val(24'(low_supply_mv), 24'(int'(d[4:0]) * 1000 + 4000));
		end
		// every retry and blanking code
		for (i = 0; i < 16; i++) begin
			wr(`OFS_TIMING_CFG, {i[3:0], 4'(15 - i)});
			#1 chk_val(24'(retry_current_code), 24'(i));
			chk_val(24'(blank_us), 24'(bt[15 - i]));
		end
		// report masking with random faults and masks
		for (i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			m2 = {d[3:0], d[7:4]};
			wr(`OFS_DEV_MASK, d);
			wr(`OFS_OUT_MASK, m2);
			dev_fault_raw <= 6'($random(seed));
			out_fault_raw <= 3'($random(seed));
			#1 chk_val(24'(dev_fault_report), 24'(dev_fault_raw & ~d[7:2]));
			chk_val(24'(out_fault_report), 24'(out_fault_raw & ~m2[2:0]));
		end
		// interrupt: raise, mask, unmask, clear, blocked report
		@(posedge clk_sys);
		dev_fault_raw <= 6'h00;
		out_fault_raw <= 3'h0;
		wr(`OFS_DEV_MASK, 8'h00);
		wr(`OFS_IRQ_STAT, 8'hff);
		wr(`OFS_IRQ_MASK, 8'h01);
		#1 chk_val(24'(irq), 24'h0);
		@(posedge clk_sys);
		dev_fault_raw <= 6'h01;
		for (i = 0; i < 5 && irq !== 1'b1; i++) @(posedge clk_sys);
		chk_val(24'(irq), 24'h1);
		rd(`OFS_IRQ_STAT, 8'h01);
		wr(`OFS_IRQ_MASK, 8'h00);
		#1 chk_val(24'(irq), 24'h0);
		wr(`OFS_IRQ_MASK, 8'h01);
		#1 chk_val(24'(irq), 24'h1);
		wr(`OFS_IRQ_STAT, 8'h01);
		#1 chk_val(24'(irq), 24'h0);
		wr(`OFS_DEV_MASK, 8'h04);
		dev_fault_raw <= 6'h00;
		repeat (2) @(posedge clk_sys);
		dev_fault_raw <= 6'h01;
		repeat (5) @(posedge clk_sys);
		#1 chk_val(24'(irq), 24'h0);
		repeat (2) @(posedge clk_sys);
		test_done;
	end
endmodule
